// ===== inc/pfrp_pkg.sv
package pfrp_pkg;
  // Register word indices on APB (paddr[13:2]).
  // Offsets 0x10C-0x10F are multiples of four only in part, so indices
  // are kept and the byte address is four times the index.
  localparam logic [11:0] IDX_DATA_LOW = 12'h10C;
  localparam logic [11:0] IDX_DATA_HIGH = 12'h10E;
  localparam logic [11:0] IDX_ADDR_LOW = 12'h10D;
  localparam logic [11:0] IDX_ADDR_HIGH = 12'h10F;
  localparam logic [11:0] IDX_CONTROL = 12'h18C;
  localparam int ADDR_BITS = 13;
  localparam int DATA_BITS = 14;
  localparam int MEM_WORDS = 2048;
  localparam int MEM_ABITS = 11;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RSVD_BIT = 7;
  localparam logic [7:0] CTRL_RSVD_VAL = 8'h80;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    PFRP_IDLE = 2'b00,
    PFRP_WAIT = 2'b01,
    PFRP_READ = 2'b11,
    PFRP_LOAD = 2'b10
  } pfrp_state_t;
endpackage

// ===== sim/pfrp_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfrp_flash_model (
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic [10:0] addr_i,
  input wire logic [13:0] data_i,
  output logic load_en_o,
  output logic [10:0] load_addr_o,
  output logic [13:0] load_data_o
);
  always_ff @(posedge ref_clk_i)
  begin
    load_en_o <= go_i;
    load_addr_o <= addr_i;
    load_data_o <= data_i;
  end
endmodule
`default_nettype wire

// ===== sim/pfrp_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pfrp_top_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic read_busy_o,
  input wire logic discard_slot_o
);
  logic rd;
  logic wr;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite && pstrb[0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_slot_timing: assert property ($rose(read_busy_o) |->
    ##2 discard_slot_o ##1 !discard_slot_o) else $error("slot late");
  chk_busy_span: assert property ($rose(read_busy_o) |->
    read_busy_o[*4] ##1 !read_busy_o) else $error("busy span");
  chk_slot_single: assert property (discard_slot_o |=>
    !discard_slot_o) else $error("slot long");
  chk_ctrl_bits: assert property (rd && paddr == 14'h0630 |->
    prdata == {24'h0, 7'h40, read_busy_o}) else $error("ctrl bits");
  chk_dhigh_zero: assert property (rd && paddr == 14'h0438 |->
    prdata[31:6] == 26'h0) else $error("data high");
  chk_ahigh_zero: assert property (rd && paddr == 14'h043C |->
    prdata[31:5] == 27'h0) else $error("addr high");
  chk_hw_clear: assert property ($fell(read_busy_o) |->
    $past(discard_slot_o, 2)) else $error("start cleared");
  chk_start_set: assert property (!read_busy_o && wr &&
    paddr == 14'h0630 && pwdata[0] |=> read_busy_o) else $error("no start");
  cover property ($rose(read_busy_o));
  cover property (discard_slot_o);
  cover property (rd && paddr == 14'h0430);
endmodule
bind pfrp_top pfrp_top_assertions u_chk (.*);
`default_nettype wire

// ===== sim/test_program_flash_read_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_program_flash_read_port;
  logic ref_clk_i, rst_i, psel, penable, pwrite, code_protect_i, go, ld_en;
  logic pready, pslverr, busy, disc, e;
  logic [13:0] paddr, d, ld_d;
  logic [31:0] pwdata, prdata, rd_q, r;
  logic [3:0] pstrb;
  logic [10:0] ga, ld_a;
  logic [12:0] a;
  int failures, checks, ex, mem[int];
  pfrp_top dut_u (.ref_clk_i, .rst_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .code_protect_i,
    .load_en_i(ld_en), .load_addr_i(ld_a), .load_data_i(ld_d),
    .read_busy_o(busy), .discard_slot_o(disc));
  pfrp_flash_model flash_u (.ref_clk_i, .go_i(go), .addr_i(ga), .data_i(d),
    .load_en_o(ld_en), .load_addr_o(ld_a), .load_data_o(ld_d));
  always @(posedge ref_clk_i) rd_q <= prdata;
  initial
  begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e)
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    if (g !== e)
      failures++;
  endtask
  task automatic apb(logic w, logic [13:0] ad, logic [7:0] v);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, v};
    @(posedge ref_clk_i);
    penable <= 1'h1;
    do @(posedge ref_clk_i); while (pready !== 1'h1);
    // The error flag only stands in the access phase, so take it here.
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge ref_clk_i);
    r = rd_q;
    @(posedge ref_clk_i);
  endtask
  task automatic complete_run;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    complete_run();
  end
  initial
  begin
    {rst_i, psel, penable, pwrite, code_protect_i, go} = 6'h20;
    {paddr, pwdata, ga, d} = 71'h0;
    pstrb = 4'hF;
    r = $urandom(32'hD5D213DE);
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    @(posedge ref_clk_i);
    apb(1'h0, 14'h0630, 8'h00);
    chk(r, 32'h80);
    chk({31'h0, e}, 32'h0);
    apb(1'h0, 14'h0004, 8'h00);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'h1, 14'h0430, 8'hA5);
    apb(1'h0, 14'h0430, 8'h00);
    chk(r, 32'hA5);
    apb(1'h1, 14'h0438, 8'hFF);
    apb(1'h0, 14'h0438, 8'h00);
    chk(r, 32'h3F);
    for (int i = 0; i < 12; i++)
    begin
      a = i == 0 ? 13'h0 : i == 1 ? 13'h7FF : 13'($urandom % 2048);
      a = i == 2 ? 13'h1FFF : a;
      d <= 14'($urandom);
      ga <= a[10:0];
      go <= a < 13'h800;
      code_protect_i <= i[0];
      @(posedge ref_clk_i);
      go <= 1'h0;
      if (a < 13'h800)
        mem[a] = d;
      ex = mem.exists(a) ? mem[a] : 0;
      apb(1'h1, 14'h043C, {3'h0, a[12:8]});
      apb(1'h1, 14'h0434, a[7:0]);
      apb(1'h1, 14'h0630, 8'h01);
      // A zero written mid-read must not abort it.
      apb(1'h1, 14'h0630, 8'h00);
      r = 32'h1;
      for (int n = 0; n < 20 && r[0]; n++)
        apb(1'h0, 14'h0630, 8'h00);
      chk(r, 32'h80);
      apb(1'h0, 14'h043C, 8'h00);
      chk(r, {27'h0, a[12:8]});
      apb(1'h0, 14'h0430, 8'h00);
      chk(r, ex & 32'hFF);
      apb(1'h0, 14'h0438, 8'h00);
      chk(r, ex >> 8);
    end
    complete_run();
  end
endmodule
`default_nettype wire

// ===== src/pfrp_rom.sv
`timescale 1ns/1ns
`default_nettype none
module pfrp_rom #(
  parameter int WORDS = 2048,
  parameter int ABITS = 11,
  parameter int WIDTH = 14
) (
  input wire logic ref_clk_i,
  input wire logic rd_en_i,
  input wire logic [ABITS-1:0] rd_addr_i,
  input wire logic wr_en_i,
  input wire logic [ABITS-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [WORDS];
  initial
  begin
    if (WORDS > (1 << ABITS))
      $error("pfrp_rom: WORDS exceeds the address range.");
  end
  // The loading port stands in for the programming path of the array.
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
    if (rd_en_i)
      rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// ===== src/pfrp_top.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [R1] Read word is 14 bits across high and low data byte registers.
// [R2] Flash address comes from high and low address bytes, 13 bits.
// [R3] Address registers express up to 8K words.
// [R4] Implemented flash holds 2K words, addresses 0 to 07FFh.
// [R5] Data high bits 7:6 and address high bits 7:5 read zero.
// [R6] Software writes high and low address bytes, upper bits zero.
// [R7] Only whole-word reads of the array are offered.
// [R8] Software loads both address bytes before setting read start.
// [R9] Read start bit is set-only by software, cleared by hardware.
// [R10] Control bit 7 is reserved and reads as one.
// [R11] Control bits 6 to 1 read as zero.
// [R12] Array read happens in the second cycle after read start.
// [R13] Word appears in data registers the cycle after the array read.
// [R14] Data registers hold until another read or a software write.
// [R15] Any location is readable regardless of code protection.
// [R16] Read start clears in the same cycle the data is captured.
module pfrp_top
  import pfrp_pkg::*;
#(
  parameter int WORDS = pfrp_pkg::MEM_WORDS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic code_protect_i,
  input wire logic load_en_i,
  input wire logic [pfrp_pkg::MEM_ABITS-1:0] load_addr_i,
  input wire logic [pfrp_pkg::DATA_BITS-1:0] load_data_i,
  output logic read_busy_o,
  output logic discard_slot_o
);
  import pfrp_pkg::*;

  initial
  begin
    if (WORDS < 1 || WORDS > MEM_WORDS)
      $error("pfrp_top: WORDS out of range.");
  end

  logic [7:0] data_low;
  logic [5:0] data_high;
  logic [7:0] addr_low;
  logic [4:0] addr_high;
  logic start;
  pfrp_state_t state;
  logic [7:0] next_data_low;
  logic [5:0] next_data_high;
  logic [7:0] next_addr_low;
  logic [4:0] next_addr_high;
  logic next_start;
  pfrp_state_t next_state;
  logic [DATA_BITS-1:0] rom_q;
  logic [ADDR_BITS-1:0] word_addr;
  logic in_range;
  logic in_range_q;
  logic next_in_range_q;
  logic rom_rd;
  logic wr_acc;
  logic rd_acc;
  logic [11:0] idx;
  logic mapped;
  logic [7:0] rd_byte;

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign idx = paddr[13:2];
  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign rd_acc = psel && penable && !pwrite;
  assign word_addr = {addr_high, addr_low}; // see [R2] see [R3]
  // Addresses past the array return zero rather than aliasing.
  assign in_range = (word_addr < ADDR_BITS'(WORDS)); // see [R4]
  assign rom_rd = (state == PFRP_READ);
  assign read_busy_o = start;
  // The slot occupied by the array read is the one the core drops.
  assign discard_slot_o = (state == PFRP_READ); // see [R12]

  always_comb
  begin
    mapped = 1'b1;
    rd_byte = RESET_BYTE;
    unique case (idx)
      IDX_DATA_LOW: rd_byte = data_low;
      IDX_DATA_HIGH: rd_byte = {2'b00, data_high}; // see [R5] see [R1]
      IDX_ADDR_LOW: rd_byte = addr_low;
      IDX_ADDR_HIGH: rd_byte = {3'b000, addr_high}; // see [R5]
      // Reserved bit forced high, unused bits low.
      IDX_CONTROL: rd_byte = CTRL_RSVD_VAL | {7'h00, start}; // see [R10] see [R11]
      default: mapped = 1'b0;
    endcase
  end

  assign prdata = rd_acc ? {24'h000000, rd_byte} : UNMAPPED_READ;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    next_data_low = data_low;
    next_data_high = data_high;
    next_addr_low = addr_low;
    next_addr_high = addr_high;
    next_start = start;
    next_state = state;
    next_in_range_q = in_range_q;
    if (wr_acc)
    begin
      unique case (idx)
        IDX_DATA_LOW: next_data_low = pwdata[7:0]; // see [R14]
        IDX_DATA_HIGH: next_data_high = pwdata[5:0]; // see [R14]
        IDX_ADDR_LOW: next_addr_low = pwdata[7:0];
        IDX_ADDR_HIGH: next_addr_high = pwdata[4:0];
        IDX_CONTROL:
        begin
          // Writing zero never clears a read in flight.
          if (pwdata[CTRL_START_BIT])
            next_start = 1'b1; // see [R9]
        end
        default: next_start = start;
      endcase
    end
    unique case (state)
      PFRP_IDLE:
      begin
        if (start)
          next_state = PFRP_WAIT;
      end
      PFRP_WAIT:
      begin
        // First slot after the set runs normally.
        next_state = PFRP_READ; // see [R12]
      end
      PFRP_READ:
      begin
        // Code protection is deliberately not consulted here.
        next_in_range_q = in_range; // see [R15]
        next_state = PFRP_LOAD;
      end
      PFRP_LOAD:
      begin
        // A full word lands at once; no byte access to the array.
        next_data_low = in_range_q ? rom_q[7:0] : RESET_BYTE; // see [R7] see [R13]
        next_data_high = in_range_q ? rom_q[13:8] : 6'h00; // see [R1]
        next_start = 1'b0; // see [R16] see [R9]
        next_state = PFRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_low <= RESET_BYTE;
      data_high <= 6'h00;
      addr_low <= RESET_BYTE;
      addr_high <= 5'h00;
      start <= 1'b0;
      state <= PFRP_IDLE;
      in_range_q <= 1'b0;
    end
    else
    begin
      data_low <= next_data_low;
      data_high <= next_data_high;
      addr_low <= next_addr_low;
      addr_high <= next_addr_high;
      start <= next_start;
      state <= next_state;
      in_range_q <= next_in_range_q;
    end
  end

  pfrp_rom #(
    .WORDS(WORDS),
    .ABITS(MEM_ABITS),
    .WIDTH(DATA_BITS)
  ) u_rom (
    .ref_clk_i(ref_clk_i),
    .rd_en_i(rom_rd),
    .rd_addr_i(word_addr[MEM_ABITS-1:0]),
    .wr_en_i(load_en_i),
    .wr_addr_i(load_addr_i),
    .wr_data_i(load_data_i),
    .rd_data_o(rom_q)
  );

  // The protect strap is accepted but has no effect on reads.
  logic unused_ok;
  assign unused_ok = code_protect_i ^ (^pwdata[31:8]) ^ (^pstrb[3:1]);
endmodule
`default_nettype wire
